//--- dv/srr_tester.sv
// self-test responder standing in for the hardware under test
`timescale 1ns/1ps
module srr_tester #(
	parameter int unsigned LAT = 8
) (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	input  wire logic go_i,
	input  wire logic fail_i,
	output logic      done_o,
	output logic      fail_o
);
	int cnt;
	// fail level is only meaningful with done; it toggles otherwise
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt <= 0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
		end
		else
		begin
			done_o <= (cnt == 1);
			fail_o <= (cnt == 1) ? fail_i : ~fail_o;
			if (go_i)
				cnt <= LAT;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

//--- dv/test_status_reporting_regs.sv
// testbench for the status reporting register bank
`timescale 1ns/1ps
module test_status_reporting_regs;
	logic        clk_sys_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [14:0] oper_cond_i = '0;
	logic [14:0] ques_cond_i = '0;
	logic        inst_reset_i = 1'b0;
	logic        preset_i = 1'b0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [3:0]  sel_i = '0;
	logic [14:0] wdata_i = '0;
	logic [14:0] rdata_o;
	logic        rvalid_o;
	logic        err_push_i = 1'b0;
	logic [15:0] err_code_i = '0;
	logic        err_pop_i = 1'b0;
	logic [15:0] err_code_o;
	logic        err_empty_o;
	logic        err_full_o;
	logic        test_start_i = 1'b0;
	logic        test_go_o;
	logic        test_done_i;
	logic        test_fail_i;
	logic        test_query_i = 1'b0;
	logic [1:0]  test_result_o;
	logic        oper_summary_o;
	logic        ques_summary_o;
	logic        ques_rise_o;
	logic        fail_req = 1'b0;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	// rows: select, write data, read back (condition and unmapped refuse)
	logic [3:0]  r_sel [8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'h0, 4'hf};
	logic [14:0] r_wd [8] = '{15'h7fff, 15'h0001, 15'h4000, 15'h2aaa,
		15'h5555, 15'h0000, 15'h7fff, 15'h1234};
	logic [14:0] r_ex [8] = '{15'h7fff, 15'h0001, 15'h4000, 15'h2aaa,
		15'h5555, 15'h0000, 15'h0000, 15'h0000};

	srr_status_regs DUT (
		.clk_sys_i     (clk_sys_i),
		.arst_n_i      (arst_n_i),
		.oper_cond_i   (oper_cond_i),
		.ques_cond_i   (ques_cond_i),
		.inst_reset_i  (inst_reset_i),
		.preset_i      (preset_i),
		.wr_i          (wr_i),
		.rd_i          (rd_i),
		.sel_i         (sel_i),
		.wdata_i       (wdata_i),
		.rdata_o       (rdata_o),
		.rvalid_o      (rvalid_o),
		.err_push_i    (err_push_i),
		.err_code_i    (err_code_i),
		.err_pop_i     (err_pop_i),
		.err_code_o    (err_code_o),
		.err_empty_o   (err_empty_o),
		.err_full_o    (err_full_o),
		.test_start_i  (test_start_i),
		.test_go_o     (test_go_o),
		.test_done_i   (test_done_i),
		.test_fail_i   (test_fail_i),
		.test_query_i  (test_query_i),
		.test_result_o (test_result_o),
		.oper_summary_o(oper_summary_o),
		.ques_summary_o(ques_summary_o),
		.ques_rise_o   (ques_rise_o)
	);
	srr_tester u_tst (
		.clk_sys_i(clk_sys_i),
		.arst_n_i (arst_n_i),
		.go_i     (test_go_o),
		.fail_i   (fail_req),
		.done_o   (test_done_i),
		.fail_o   (test_fail_i)
	);

	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic close_out();
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wr(input logic [3:0] s, input logic [14:0] d);
		@(posedge clk_sys_i) {wr_i, sel_i, wdata_i} <= {1'b1, s, d};
		@(posedge clk_sys_i) wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] s, input logic [14:0] e);
		@(posedge clk_sys_i) {rd_i, sel_i} <= {1'b1, s};
		@(posedge clk_sys_i) rd_i <= 1'b0;
		#1;
		chk({15'h0, rvalid_o}, 16'h1);
		chk({1'b0, rdata_o}, {1'b0, e});
	endtask

	task automatic pop(input logic [15:0] e);
		@(posedge clk_sys_i) err_pop_i <= 1'b1;
		@(posedge clk_sys_i) err_pop_i <= 1'b0;
		#1 chk(err_code_o, e);
	endtask

	task automatic query(input logic [1:0] e);
		@(posedge clk_sys_i) test_query_i <= 1'b1;
		@(posedge clk_sys_i) test_query_i <= 1'b0;
		#1 chk({14'h0, test_result_o}, {14'h0, e});
	endtask

	// rise filters all ones, fall filters and enables zero
	task automatic chk_preset();
		for (int i = 0; i < 6; i++)
			rd(r_sel[i], (i == 2 || i == 5) ? 15'h7fff : 15'h0);
	endtask

	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			close_out();
		end
	end

	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		chk_preset();
		query(2'h3);
		pop(16'h0);
		for (int i = 0; i < 8; i++)
		begin
			wr(r_sel[i], r_wd[i]);
			rd(r_sel[i], r_ex[i]);
		end
		@(posedge clk_sys_i) inst_reset_i <= 1'b1;
		@(posedge clk_sys_i) inst_reset_i <= 1'b0;
		rd(4'h8, 15'h5555);
		// a write in the preset cycle must lose
		@(posedge clk_sys_i) {preset_i, wr_i, sel_i} <= {2'b11, 4'h1};
		@(posedge clk_sys_i) {preset_i, wr_i} <= 2'b00;
		chk_preset();
		wr(4'h3, 15'h0002);
		wr(4'h4, 15'h7ffd);
		oper_cond_i <= 15'h0001;
		wait_n(3);
		@(posedge clk_sys_i) oper_cond_i <= 15'h0007;
		wait_n(3);
		chk({15'h0, oper_summary_o}, 16'h0);
		rd(4'h0, 15'h0007);
		rd(4'h0, 15'h0007);
		rd(4'h2, 15'h0005);
		rd(4'h2, 15'h0000);
		@(posedge clk_sys_i) oper_cond_i <= 15'h0000;
		wait_n(3);
		wr(4'h1, 15'h0002);
		wait_n(2);
		chk({15'h0, oper_summary_o}, 16'h1);
		rd(4'h2, 15'h0002);
		wr(4'h6, 15'h0004);
		ques_cond_i <= 15'h0004;
		for (int k = 0; k < 6 && ques_rise_o !== 1'b1; k++)
			wait_n(1);
		chk({14'h0, ques_summary_o, ques_rise_o}, 16'h3);
		wait_n(1);
		chk({14'h0, ques_summary_o, ques_rise_o}, 16'h2);
		rd(4'h5, 15'h0004);
		rd(4'h7, 15'h0004);
		wait_n(2);
		chk({15'h0, ques_summary_o}, 16'h0);
		for (int i = 1; i < 10; i++)
		begin
			@(posedge clk_sys_i) err_push_i <= 1'b1;
			err_code_i <= (i == 2) ? 16'hfffd : 16'(i);
			@(posedge clk_sys_i) err_push_i <= 1'b0;
		end
		#1 chk({15'h0, err_full_o}, 16'h1);
		for (int i = 1; i < 9; i++)
			pop((i == 2) ? 16'hfffd : 16'(i));
		pop(16'h0);
		chk({15'h0, err_empty_o}, 16'h1);
		for (int f = 0; f < 2; f++)
		begin
			fail_req <= f[0];
			@(posedge clk_sys_i) test_start_i <= 1'b1;
			@(posedge clk_sys_i) test_start_i <= 1'b0;
			#1 chk({15'h0, test_go_o}, 16'h1);
			query(2'h2);
			for (int k = 0; k < 20 && test_done_i !== 1'b1; k++)
				@(posedge clk_sys_i);
			query(f[0] ? 2'h1 : 2'h0);
		end
		close_out();
	end
endmodule

//--- src/srr_err_fifo.sv
// error queue: oldest error first, zero when popped while empty
`timescale 1ns/1ps
module srr_err_fifo #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW = 3
) (
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic        push_i,
	input  wire logic [15:0] code_i,
	input  wire logic        pop_i,
	output logic      [15:0] code_o,
	output logic             empty_o,
	output logic             full_o
);
	typedef struct packed
	{
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
		logic [15:0]   code;
	} srr_fifo_s;
	srr_fifo_s st;
	srr_fifo_s next_st;
	logic [15:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign empty_o = (st.cnt == '0);
	assign full_o = (st.cnt == (AW+1)'(DEPTH));
	assign do_pop = pop_i && !empty_o;
	// a full queue drops the newest error rather than overwrite history
	assign do_push = push_i && (!full_o || do_pop);
	assign code_o = st.code;

	always_comb
	begin
		next_st = st;
		if (do_push)
			next_st.wr = st.wr + 1'b1;
		if (pop_i)
		begin
			next_st.code = empty_o ? srr_pkg::NO_ERROR : mem[st.rd]; // RULE14 RULE15
			if (do_pop)
				next_st.rd = st.rd + 1'b1; // RULE14
		end
		next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (do_push)
			mem[st.wr] <= code_i;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

//--- src/srr_pkg.sv
// shared constants for the status reporting register bank
package srr_pkg;
	localparam int unsigned REG_W = 15;
	localparam logic [14:0] ALL_ONES = 15'h7fff;
	localparam logic [14:0] ZERO = 15'h0000;
	// register select codes on the command port
	localparam logic [3:0] SEL_OPER_COND = 4'h0;
	localparam logic [3:0] SEL_OPER_ENAB = 4'h1;
	localparam logic [3:0] SEL_OPER_EVNT = 4'h2;
	localparam logic [3:0] SEL_OPER_FALL = 4'h3;
	localparam logic [3:0] SEL_OPER_RISE = 4'h4;
	localparam logic [3:0] SEL_QUES_COND = 4'h5;
	localparam logic [3:0] SEL_QUES_ENAB = 4'h6;
	localparam logic [3:0] SEL_QUES_EVNT = 4'h7;
	localparam logic [3:0] SEL_QUES_FALL = 4'h8;
	localparam logic [3:0] SEL_QUES_RISE = 4'h9;
	// self-test result codes
	localparam logic [1:0] TEST_PASS = 2'h0;
	localparam logic [1:0] TEST_FAIL = 2'h1;
	localparam logic [1:0] TEST_RUNNING = 2'h2;
	localparam logic [1:0] TEST_STOPPED = 2'h3;
	typedef enum logic [1:0]
	{
		SRR_ST_STOPPED = 2'b00,
		SRR_ST_RUNNING = 2'b01,
		SRR_ST_DONE = 2'b10
	} srr_test_e;
	localparam int unsigned ERR_W = 16;
	localparam logic [15:0] NO_ERROR = 16'h0000;
endpackage

//--- src/srr_status_regs.sv
// operation/questionable status groups, error queue and self-test handshake
`timescale 1ns/1ps
// Behaviour
// RULE1: instrument reset leaves status parts unchanged
// RULE2: every part holds fifteen bits
// RULE3: condition read shows live bits, no clear
// RULE4: event read returns bits then clears
// RULE5: event bits stay set until read
// RULE6: enabled falling condition bit sets event
// RULE7: enabled rising condition bit sets event
// RULE8: enable mask selects events for summary
// RULE9: enabled set event raises summary bit
// RULE10: questionable summary rise goes upward
// RULE11: preset loads rise filters all ones
// RULE12: preset clears fall filters
// RULE13: preset clears both enable masks
// RULE14: error queue first in first out
// RULE15: empty error queue answers zero
// RULE16: positive device, negative standard error codes
// RULE17: start self-test then query; zero passes
// RULE18: result reports pass fail running stopped
// RULE19: summary is OR of event AND enable
module srr_status_regs #(
	parameter int unsigned ERR_DEPTH = 8,
	parameter int unsigned ERR_AW = 3
) (
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic [14:0] oper_cond_i,
	input  wire logic [14:0] ques_cond_i,
	input  wire logic        inst_reset_i,
	input  wire logic        preset_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [14:0] wdata_i,
	output logic      [14:0] rdata_o,
	output logic             rvalid_o,
	input  wire logic        err_push_i,
	input  wire logic [15:0] err_code_i,
	input  wire logic        err_pop_i,
	output logic      [15:0] err_code_o,
	output logic             err_empty_o,
	output logic             err_full_o,
	input  wire logic        test_start_i,
	output logic             test_go_o,
	input  wire logic        test_done_i,
	input  wire logic        test_fail_i,
	input  wire logic        test_query_i,
	output logic      [1:0]  test_result_o,
	output logic             oper_summary_o,
	output logic             ques_summary_o,
	output logic             ques_rise_o
);
	typedef struct packed
	{
		logic [14:0] oper_prev;
		logic [14:0] oper_enab;
		logic [14:0] oper_evnt;
		logic [14:0] oper_fall;
		logic [14:0] oper_rise;
		logic [14:0] ques_prev;
		logic [14:0] ques_enab;
		logic [14:0] ques_evnt;
		logic [14:0] ques_fall;
		logic [14:0] ques_rise;
		logic [14:0] rdata;
		logic        rvalid;
		logic        oper_sum;
		logic        ques_sum;
		logic        ques_pulse;
		srr_pkg::srr_test_e test_st;
		logic        test_failed;
		logic        test_go;
		logic [1:0]  test_result;
	} srr_regs_s;

	srr_regs_s st;
	srr_regs_s next_st;
	logic [14:0] oper_hits;
	logic [14:0] ques_hits;
	logic        oper_evnt_rd;
	logic        ques_evnt_rd;
	logic        oper_sum_now;
	logic        ques_sum_now;

	// transitions picked by the two filters
	function automatic logic [14:0] edge_hits(
		input logic [14:0] cur,
		input logic [14:0] prev,
		input logic [14:0] rise,
		input logic [14:0] fall
	);
		edge_hits = (cur & ~prev & rise) | (~cur & prev & fall);
	endfunction

	assign oper_hits = edge_hits(oper_cond_i, st.oper_prev,
		st.oper_rise, st.oper_fall); // RULE6 RULE7
	assign ques_hits = edge_hits(ques_cond_i, st.ques_prev,
		st.ques_rise, st.ques_fall); // RULE6 RULE7
	assign oper_evnt_rd = rd_i && (sel_i == srr_pkg::SEL_OPER_EVNT);
	assign ques_evnt_rd = rd_i && (sel_i == srr_pkg::SEL_QUES_EVNT);

	always_comb
	begin
		next_st = st;
		next_st.oper_prev = oper_cond_i;
		next_st.ques_prev = ques_cond_i;
		next_st.rvalid = rd_i;
		next_st.test_go = 1'b0;
		// hits arriving in the read cycle survive the clear
		next_st.oper_evnt = (oper_evnt_rd ? srr_pkg::ZERO : st.oper_evnt)
			| oper_hits; // RULE4 RULE5
		next_st.ques_evnt = (ques_evnt_rd ? srr_pkg::ZERO : st.ques_evnt)
			| ques_hits; // RULE4 RULE5
		if (rd_i)
		begin
			if (sel_i == srr_pkg::SEL_OPER_COND)
				next_st.rdata = oper_cond_i; // RULE3
			else if (sel_i == srr_pkg::SEL_OPER_ENAB)
				next_st.rdata = st.oper_enab;
			else if (sel_i == srr_pkg::SEL_OPER_EVNT)
				next_st.rdata = st.oper_evnt; // RULE4
			else if (sel_i == srr_pkg::SEL_OPER_FALL)
				next_st.rdata = st.oper_fall;
			else if (sel_i == srr_pkg::SEL_OPER_RISE)
				next_st.rdata = st.oper_rise;
			else if (sel_i == srr_pkg::SEL_QUES_COND)
				next_st.rdata = ques_cond_i; // RULE3
			else if (sel_i == srr_pkg::SEL_QUES_ENAB)
				next_st.rdata = st.ques_enab;
			else if (sel_i == srr_pkg::SEL_QUES_EVNT)
				next_st.rdata = st.ques_evnt; // RULE4
			else if (sel_i == srr_pkg::SEL_QUES_FALL)
				next_st.rdata = st.ques_fall;
			else if (sel_i == srr_pkg::SEL_QUES_RISE)
				next_st.rdata = st.ques_rise;
			else
				next_st.rdata = srr_pkg::ZERO;
		end
		if (wr_i)
		begin
			// fifteen-bit parts, so 0..32767 is the whole range
			if (sel_i == srr_pkg::SEL_OPER_ENAB)
				next_st.oper_enab = wdata_i; // RULE2
			else if (sel_i == srr_pkg::SEL_OPER_FALL)
				next_st.oper_fall = wdata_i;
			else if (sel_i == srr_pkg::SEL_OPER_RISE)
				next_st.oper_rise = wdata_i;
			else if (sel_i == srr_pkg::SEL_QUES_ENAB)
				next_st.ques_enab = wdata_i;
			else if (sel_i == srr_pkg::SEL_QUES_FALL)
				next_st.ques_fall = wdata_i;
			else if (sel_i == srr_pkg::SEL_QUES_RISE)
				next_st.ques_rise = wdata_i;
		end
		// preset outranks a write in the same cycle
		if (preset_i) // RULE1
		begin
			next_st.oper_rise = srr_pkg::ALL_ONES; // RULE11
			next_st.ques_rise = srr_pkg::ALL_ONES; // RULE11
			next_st.oper_fall = srr_pkg::ZERO; // RULE12
			next_st.ques_fall = srr_pkg::ZERO; // RULE12
			next_st.oper_enab = srr_pkg::ZERO; // RULE13
			next_st.ques_enab = srr_pkg::ZERO; // RULE13
		end
		// inst_reset_i is deliberately not used for any status part
		next_st.oper_sum = oper_sum_now;
		next_st.ques_sum = ques_sum_now;
		next_st.ques_pulse = ques_sum_now && !st.ques_sum; // RULE10
		case (st.test_st)
			srr_pkg::SRR_ST_STOPPED,
			srr_pkg::SRR_ST_DONE:
			begin
				if (test_start_i)
				begin
					next_st.test_st = srr_pkg::SRR_ST_RUNNING; // RULE17
					next_st.test_go = 1'b1;
				end
			end
			srr_pkg::SRR_ST_RUNNING:
			begin
				if (test_done_i)
				begin
					next_st.test_st = srr_pkg::SRR_ST_DONE;
					next_st.test_failed = test_fail_i;
				end
			end
			default:
				next_st.test_st = srr_pkg::SRR_ST_STOPPED;
		endcase
		if (test_query_i)
		begin
			case (st.test_st)
				srr_pkg::SRR_ST_RUNNING:
					next_st.test_result = srr_pkg::TEST_RUNNING; // RULE18
				srr_pkg::SRR_ST_DONE:
					next_st.test_result = st.test_failed ?
						srr_pkg::TEST_FAIL : srr_pkg::TEST_PASS; // RULE17
				default:
					next_st.test_result = srr_pkg::TEST_STOPPED; // RULE18
			endcase
		end
	end

	// summary follows the event part one cycle after the event lands
	assign oper_sum_now = |(st.oper_evnt & st.oper_enab); // RULE8 RULE19
	assign ques_sum_now = |(st.ques_evnt & st.ques_enab); // RULE9 RULE19

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st <= '0;
			st.oper_rise <= srr_pkg::ALL_ONES;
			st.ques_rise <= srr_pkg::ALL_ONES;
			st.test_st <= srr_pkg::SRR_ST_STOPPED;
			st.test_result <= srr_pkg::TEST_STOPPED;
		end
		else
			st <= next_st;
	end

	srr_err_fifo #(
		.DEPTH(ERR_DEPTH),
		.AW   (ERR_AW)
	) u_err_fifo (
		.clk_sys_i(clk_sys_i),
		.arst_n_i (arst_n_i),
		.push_i   (err_push_i), // RULE16
		.code_i   (err_code_i),
		.pop_i    (err_pop_i),
		.code_o   (err_code_o),
		.empty_o  (err_empty_o),
		.full_o   (err_full_o)
	);

	assign rdata_o = st.rdata;
	assign rvalid_o = st.rvalid;
	assign oper_summary_o = st.oper_sum;
	assign ques_summary_o = st.ques_sum;
	assign ques_rise_o = st.ques_pulse;
	assign test_go_o = st.test_go;
	assign test_result_o = st.test_result;

	sequence s_ques_rise;
		$rose(ques_cond_i[2]) && st.ques_rise[2] && !preset_i;
	endsequence

	sequence s_go_once;
		test_go_o ##1 !test_go_o;
	endsequence

	a_event_sets: assert property ( // RULE7
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_ques_rise |=> st.ques_evnt[2])
		else $error("enabled rise did not set event");
	a_rise_masked: assert property ( // RULE7
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(oper_cond_i[1]) && !st.oper_rise[1] && !st.oper_evnt[1]
		|=> !st.oper_evnt[1])
		else $error("masked rise set event");
	a_fall_sets: assert property ( // RULE6
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$fell(oper_cond_i[1]) && st.oper_fall[1] |=> st.oper_evnt[1])
		else $error("enabled fall did not set event");
	a_fall_masked: assert property ( // RULE6
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$fell(oper_cond_i[0]) && !st.oper_fall[0] && !st.oper_evnt[0]
		|=> !st.oper_evnt[0])
		else $error("masked fall set event");
	a_read_clears: assert property ( // RULE4
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		oper_evnt_rd && oper_hits == srr_pkg::ZERO
		|=> st.oper_evnt == srr_pkg::ZERO)
		else $error("event read did not clear");
	a_ques_clears: assert property ( // RULE4
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		ques_evnt_rd && ques_hits == srr_pkg::ZERO
		|=> st.ques_evnt == srr_pkg::ZERO)
		else $error("questionable event read did not clear");
	a_event_rdata: assert property ( // RULE4
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		oper_evnt_rd |=> rdata_o == $past(st.oper_evnt))
		else $error("event read returned wrong bits");
	a_event_holds: assert property ( // RULE5
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		st.oper_evnt[1] && !oper_evnt_rd |=> st.oper_evnt[1])
		else $error("event bit lost without read");
	a_rvalid_set: assert property ( // RULE3
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		rd_i |=> rvalid_o)
		else $error("read not answered");
	a_rvalid_drop: assert property ( // RULE3
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		!rd_i |=> !rvalid_o)
		else $error("answer without read");
	a_cond_read: assert property ( // RULE3
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		rd_i && sel_i == srr_pkg::SEL_QUES_COND
		|=> rvalid_o && rdata_o == $past(ques_cond_i))
		else $error("condition read wrong");
	a_oper_cond_read: assert property ( // RULE3
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		rd_i && sel_i == srr_pkg::SEL_OPER_COND
		|=> rdata_o == $past(oper_cond_i))
		else $error("operation condition read wrong");
	a_enab_write: assert property ( // RULE2
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		wr_i && sel_i == srr_pkg::SEL_OPER_ENAB && !preset_i
		|=> st.oper_enab == $past(wdata_i))
		else $error("enable write lost");
	a_preset_load: assert property ( // RULE11 RULE12 RULE13
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		preset_i |=> st.oper_rise == srr_pkg::ALL_ONES
		&& st.ques_fall == srr_pkg::ZERO
		&& st.oper_enab == srr_pkg::ZERO)
		else $error("preset values wrong");
	a_preset_other: assert property ( // RULE11 RULE12 RULE13
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		preset_i |=> st.ques_rise == srr_pkg::ALL_ONES
		&& st.oper_fall == srr_pkg::ZERO
		&& st.ques_enab == srr_pkg::ZERO)
		else $error("preset values wrong in second group");
	a_inst_reset: assert property ( // RULE1
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		inst_reset_i && !preset_i && !wr_i |=> $stable(st.ques_enab))
		else $error("instrument reset touched status");
	a_summary_or: assert property ( // RULE19
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		oper_summary_o == |($past(st.oper_evnt) & $past(st.oper_enab)))
		else $error("summary mismatch");
	a_ques_summary: assert property ( // RULE9 RULE19
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		ques_summary_o == |($past(st.ques_evnt) & $past(st.ques_enab)))
		else $error("questionable summary mismatch");
	a_ques_pulse: assert property ( // RULE10
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		$rose(ques_summary_o) |-> ques_rise_o)
		else $error("questionable rise not propagated");
	a_pulse_once: assert property ( // RULE10
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		ques_rise_o |-> ques_summary_o ##1 !ques_rise_o)
		else $error("questionable rise not a single pulse");
	a_go_pulse: assert property ( // RULE17
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		test_start_i && st.test_st != srr_pkg::SRR_ST_RUNNING
		|=> s_go_once)
		else $error("start did not give one go pulse");
	a_test_run: assert property ( // RULE18
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		st.test_st == srr_pkg::SRR_ST_RUNNING && test_query_i
		&& !test_done_i |=> test_result_o == srr_pkg::TEST_RUNNING)
		else $error("running not reported");
	a_test_stopped: assert property ( // RULE18
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		st.test_st == srr_pkg::SRR_ST_STOPPED && test_query_i
		|=> test_result_o == srr_pkg::TEST_STOPPED)
		else $error("stopped not reported");
	a_result_holds: assert property ( // RULE18
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		!test_query_i |=> $stable(test_result_o))
		else $error("result changed without query");
	a_empty_answer: assert property ( // RULE15
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		err_pop_i && err_empty_o |=> err_code_o == srr_pkg::NO_ERROR)
		else $error("empty queue answered nonzero");
endmodule
